// ===== rtl/iets_pkg.sv
// Purpose: Constants and types of the interrupt and trap block
// Assumes: One system clock; all configuration arrives on plain ports
// Notes:   Rules kept are listed below
//
// Functional notes
// (RULE1) Each request goes to interrupt or transfer engine
// (RULE2) Standard service branches to the node's vector
// (RULE3) Transfer service steals exactly one cycle
// (RULE4) Transfer moves byte/word, bumps chosen pointers
// (RULE5) Counter decrements per service unless continuous
// (RULE6) Counter reaching zero raises the source's interrupt
// (RULE7) Eight independent transfer channels
// (RULE8) Response takes 7 clocks cached, 11 otherwise
// (RULE9) 96 nodes: request, enable and priority each
// (RULE10) Selectors pick the source of shared nodes
// (RULE11) Router: 4 inputs, matrix, 4 gating stages
// (RULE12) Inputs detect rising, falling or both edges
// (RULE13) Gating filters events on pattern hit or miss
// (RULE14) Trap branches to its vector, sets flag bit
// (RULE15) Trap preempts unless higher trap is running
// (RULE16) Running trap blocks interrupts and transfers
// (RULE17) Three service pins make system requests zero/one
// (RULE18) Software trap number invokes that service
// (RULE19) Software request bit acts like hardware source
// (RULE20) Highest enabled priority above CPU level wins
package iets_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int NUM_NODES     = 96;
  localparam int NODE_W        = 7;
  localparam int PRIO_W        = 4;
  localparam int NUM_PEC       = 8;
  localparam int PEC_CH_W      = 3;
  localparam int ADDR_W        = 16;
  localparam int CNT_W         = 8;
  localparam int NUM_SHARED    = 8;
  localparam int SHARED_BASE   = 88;
  localparam int ERU_CH        = 4;
  localparam int ERU_OUT       = 4;
  localparam int ERU_NODE_BASE = 80;
  localparam int NUM_ESR       = 3;
  localparam int NUM_PINS      = 7;
  localparam int NUM_TRAPS     = 8;
  localparam int TRAP_W        = 3;
  localparam int TRAP_SR0_BIT  = 6;
  localparam int TRAP_SR1_BIT  = 7;
  localparam int VEC_W         = 7;
  localparam int LAT_W         = 4;

  // ---------------------------------------------------------------------
  // Vectors, timing and reset values
  // ---------------------------------------------------------------------
  localparam logic [VEC_W-1:0]  TRAP_VEC_BASE  = 7'h00;
  localparam logic [VEC_W-1:0]  NODE_VEC_BASE  = 7'h10;
  localparam logic [LAT_W-1:0]  RESP_CLKS_JC   = 4'h7;
  localparam logic [LAT_W-1:0]  RESP_CLKS_NJC  = 4'hB;
  localparam logic [LAT_W-1:0]  RESP_PIPE      = 4'h2;
  localparam logic [ADDR_W-1:0] PTR_STEP_BYTE  = 16'h0001;
  localparam logic [ADDR_W-1:0] PTR_STEP_WORD  = 16'h0002;
  localparam logic [ADDR_W-1:0] ADDR_RST       = 16'h0000;
  localparam logic [CNT_W-1:0]  PEC_CNT_RST    = 8'h00;

  // Gating stage modes
  localparam logic [1:0] GATE_OFF    = 2'h0;
  localparam logic [1:0] GATE_ALWAYS = 2'h1;
  localparam logic [1:0] GATE_HIT    = 2'h2;
  localparam logic [1:0] GATE_MISS   = 2'h3;

  // Service sequencer, Gray along idle-wait-int and idle-pec
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_INT  = 2'h3,
    ST_PEC  = 2'h2
  } iets_state_e;

endpackage : iets_pkg

// ===== rtl/iets_top.sv
// Purpose: Interrupt nodes, transfer engine, request router and traps
// Assumes: hw requests are one-cycle pulses on sys_clk_i; pins are async
// Notes:   Registered outputs; a flag's set beats its clear
`timescale 1ns/1ps
`default_nettype none
module iets_top
  import iets_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  // Node sources and configuration
  input  wire logic [SHARED_BASE-1:0]        hw_req_i,
  input  wire logic [NUM_SHARED-1:0]         shared_a_i,
  input  wire logic [NUM_SHARED-1:0]         shared_b_i,
  input  wire logic [NUM_SHARED-1:0]         source_select_regs_i,
  input  wire logic [NUM_NODES-1:0]          node_en_i,
  input  wire logic [NUM_NODES*PRIO_W-1:0]   node_prio_i,
  input  wire logic [NUM_NODES-1:0]          pec_route_i,
  input  wire logic [NUM_NODES*PEC_CH_W-1:0] node_chan_i,
  input  wire logic                          request_set_bit_i,
  input  wire logic [NODE_W-1:0]             request_set_node_i,
  // CPU side
  input  wire logic [PRIO_W-1:0]             cpu_level_i,
  input  wire logic                          jump_cache_i,
  input  wire logic                          int_ack_i,
  input  wire logic                          sw_trap_i,
  input  wire logic [VEC_W-1:0]              sw_trap_num_i,
  input  wire logic                          trap_done_i,
  // Transfer engine configuration
  input  wire logic [NUM_PEC-1:0]            pec_word_i,
  input  wire logic [NUM_PEC-1:0]            pec_inc_src_i,
  input  wire logic [NUM_PEC-1:0]            pec_inc_dst_i,
  input  wire logic [NUM_PEC-1:0]            pec_cont_i,
  input  wire logic                          pec_load_i,
  input  wire logic [PEC_CH_W-1:0]           pec_load_chan_i,
  input  wire logic [ADDR_W-1:0]             pec_load_src_i,
  input  wire logic [ADDR_W-1:0]             pec_load_dst_i,
  input  wire logic [CNT_W-1:0]              pec_load_cnt_i,
  // External request router
  input  wire logic [ERU_CH-1:0]             eru_pin_i,
  input  wire logic [ERU_CH*2-1:0]           eru_edge_cfg_i,
  input  wire logic [ERU_OUT*ERU_CH-1:0]     eru_route_i,
  input  wire logic [ERU_OUT*ERU_CH-1:0]     eru_pat_mask_i,
  input  wire logic [ERU_OUT*ERU_CH-1:0]     eru_pat_val_i,
  input  wire logic [ERU_OUT*2-1:0]          eru_gate_i,
  // Traps
  input  wire logic [NUM_ESR-1:0]            external_service_pin_i,
  input  wire logic [NUM_ESR-1:0]            esr_en_i,
  input  wire logic [NUM_TRAPS-3:0]          hw_trap_i,
  input  wire logic [NUM_TRAPS-1:0]          trap_flag_clr_i,
  // Interrupt outputs
  output logic                               int_req_o,
  output logic [VEC_W-1:0]                   int_vec_o,
  output logic [PRIO_W-1:0]                  int_level_o,
  output logic [NUM_NODES-1:0]               node_pend_o,
  // Transfer outputs
  output logic                               pec_steal_o,
  output logic [PEC_CH_W-1:0]                pec_chan_o,
  output logic [ADDR_W-1:0]                  pec_src_addr_o,
  output logic [ADDR_W-1:0]                  pec_dst_addr_o,
  output logic                               pec_word_o,
  // Router and trap outputs
  output logic [ERU_OUT-1:0]                 eru_out_o,
  output logic                               trap_req_o,
  output logic [VEC_W-1:0]                   trap_vec_o,
  output logic [NUM_TRAPS-1:0]               trap_flag_reg_o,
  output logic                               trap_busy_o
);

  // ---------------------------------------------------------------------
  // Pin synchronisers and filtered levels
  // ---------------------------------------------------------------------
  logic [NUM_PINS-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [NUM_PINS-1:0] pin_lvl_reg, pin_lvl_next, pin_old_reg;
  logic [NUM_PINS-1:0] pin_rise, pin_fall;

  // Level moves only when second and third stage agree
  always_comb begin
    pin_lvl_next = (sync2_reg & sync3_reg)
                 | (pin_lvl_reg & (sync2_reg ^ sync3_reg));
    pin_rise     = pin_lvl_reg & ~pin_old_reg;
    pin_fall     = ~pin_lvl_reg & pin_old_reg;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      sync3_reg   <= '0;
      pin_lvl_reg <= '0;
      pin_old_reg <= '0;
    end else begin
      sync1_reg   <= {external_service_pin_i, eru_pin_i};
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      pin_lvl_reg <= pin_lvl_next;
      pin_old_reg <= pin_lvl_reg;
    end
  end

  // ---------------------------------------------------------------------
  // External request router
  // ---------------------------------------------------------------------
  logic [ERU_CH-1:0]  eru_ev;
  logic [ERU_OUT-1:0] eru_out_reg, eru_out_next;
  logic [ERU_CH-1:0]  eru_lvl;
  logic               pat_hit, any_ev;

  // Edge detect, routing and pattern gating
  always_comb begin
    eru_lvl = pin_lvl_reg[ERU_CH-1:0];
    for (int c = 0; c < ERU_CH; c++) begin
      eru_ev[c] = (pin_rise[c] & eru_edge_cfg_i[2*c])       // RULE12
                | (pin_fall[c] & eru_edge_cfg_i[2*c+1]);    // RULE12
    end
    eru_out_next = '0;
    for (int k = 0; k < ERU_OUT; k++) begin
      any_ev  = |(eru_ev & eru_route_i[k*ERU_CH +: ERU_CH]); // RULE11
      pat_hit = ((eru_lvl ^ eru_pat_val_i[k*ERU_CH +: ERU_CH])
                & eru_pat_mask_i[k*ERU_CH +: ERU_CH]) == '0;
      unique case (eru_gate_i[2*k +: 2])
        GATE_OFF:    eru_out_next[k] = 1'b0;
        GATE_ALWAYS: eru_out_next[k] = any_ev;
        GATE_HIT:    eru_out_next[k] = any_ev & pat_hit;    // RULE13
        GATE_MISS:   eru_out_next[k] = any_ev & ~pat_hit;   // RULE13
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      eru_out_reg <= '0;
    end else begin
      eru_out_reg <= eru_out_next;
    end
  end

  // ---------------------------------------------------------------------
  // Node sources and shared-node selection
  // ---------------------------------------------------------------------
  logic [NUM_SHARED-1:0] shared_req;
  logic [NUM_NODES-1:0]  src_req;

  // Shared node source pick
  for (genvar j = 0; j < NUM_SHARED; j++) begin : g_shared
    assign shared_req[j] = source_select_regs_i[j] ? shared_b_i[j]
                                                   : shared_a_i[j]; // RULE10
  end

  // Per-node request sources
  always_comb begin
    src_req = {shared_req, hw_req_i};
    src_req[ERU_NODE_BASE +: ERU_OUT] = hw_req_i[ERU_NODE_BASE +: ERU_OUT]
                                      | eru_out_reg;
    if (request_set_bit_i && request_set_node_i < NODE_W'(NUM_NODES)) begin
      src_req[request_set_node_i] = 1'b1;                   // RULE19
    end
  end

  // ---------------------------------------------------------------------
  // Priority arbiter over pending enabled nodes
  // ---------------------------------------------------------------------
  logic [NUM_NODES-1:0] req_reg;
  logic                 best_valid;
  logic [NODE_W-1:0]    best_idx;
  logic [PRIO_W-1:0]    best_prio;
  logic [PEC_CH_W-1:0]  win_chan;
  logic                 win_pec;
  logic [CNT_W-1:0]     cnt_reg [NUM_PEC];

  // Strictly above CPU level; lower index wins a tie
  always_comb begin
    best_valid = 1'b0;
    best_idx   = '0;
    best_prio  = cpu_level_i;
    for (int i = 0; i < NUM_NODES; i++) begin
      if (req_reg[i] && node_en_i[i]
          && node_prio_i[i*PRIO_W +: PRIO_W] > best_prio) begin // RULE20
        best_valid = 1'b1;
        best_idx   = NODE_W'(i);
        best_prio  = node_prio_i[i*PRIO_W +: PRIO_W];
      end
    end
    win_chan = node_chan_i[PEC_CH_W*best_idx +: PEC_CH_W];
    // A channel whose count ran out hands back to the interrupt path
    win_pec  = best_valid && pec_route_i[best_idx]               // RULE1
             && (pec_cont_i[win_chan] || cnt_reg[win_chan] != '0);
  end

  // ---------------------------------------------------------------------
  // Service sequencer
  // ---------------------------------------------------------------------
  iets_state_e          state_reg, state_next;
  logic [LAT_W-1:0]     lat_reg, lat_next, resp_clks;
  logic [NODE_W-1:0]    cur_node_reg, cur_node_next;
  logic [PEC_CH_W-1:0]  cur_chan_reg, cur_chan_next;
  logic                 cur_sw_reg, cur_sw_next;
  logic                 sw_pend_reg, sw_pend_next;
  logic [VEC_W-1:0]     sw_num_reg, sw_num_next;
  logic [NUM_NODES-1:0] req_next, node_clr;
  logic                 node_reset;
  logic                 int_req_reg, pec_steal_reg;
  logic [VEC_W-1:0]     int_vec_reg, int_vec_next;
  logic [PRIO_W-1:0]    int_lvl_reg, int_lvl_next;
  logic                 trap_busy_reg;

  // Next state, flags, software trap
  always_comb begin
    state_next    = state_reg;
    lat_next      = lat_reg;
    cur_node_next = cur_node_reg;
    cur_chan_next = cur_chan_reg;
    cur_sw_next   = cur_sw_reg;
    int_vec_next  = int_vec_reg;
    int_lvl_next  = int_lvl_reg;
    node_clr      = '0;
    node_reset    = 1'b0;
    sw_pend_next  = sw_pend_reg;
    sw_num_next   = sw_num_reg;
    resp_clks     = jump_cache_i ? RESP_CLKS_JC : RESP_CLKS_NJC;
    unique case (state_reg)
      ST_IDLE: begin
        if (!trap_busy_reg) begin                           // RULE16
          if (sw_pend_reg) begin
            state_next   = ST_WAIT;
            lat_next     = resp_clks - RESP_PIPE;           // RULE8
            cur_sw_next  = 1'b1;
            int_vec_next = sw_num_reg;                      // RULE18
            int_lvl_next = '1;
          end else if (win_pec) begin
            state_next            = ST_PEC;                 // RULE3
            cur_node_next         = best_idx;
            cur_chan_next         = win_chan;
            node_clr[best_idx]    = 1'b1;
          end else if (best_valid) begin
            state_next    = ST_WAIT;
            lat_next      = resp_clks - RESP_PIPE;          // RULE8
            cur_sw_next   = 1'b0;
            cur_node_next = best_idx;
            int_vec_next  = NODE_VEC_BASE + best_idx;       // RULE2
            int_lvl_next  = best_prio;
          end
        end
      end
      ST_WAIT: begin
        if (trap_busy_reg) begin
          state_next = ST_IDLE;                             // RULE15
        end else if (lat_reg == '0) begin
          state_next = ST_INT;
        end else begin
          lat_next = lat_reg - 1'b1;
        end
      end
      ST_INT: begin
        if (int_ack_i) begin
          state_next = ST_IDLE;
          if (cur_sw_reg) begin
            sw_pend_next = 1'b0;
          end else begin
            node_clr[cur_node_reg] = 1'b1;
          end
        end
      end
      ST_PEC: begin
        state_next = ST_IDLE;                               // RULE3
        node_reset = !pec_cont_i[cur_chan_reg]
                   && cnt_reg[cur_chan_reg] == CNT_W'(1);   // RULE6
      end
    endcase
    if (sw_trap_i) begin
      sw_pend_next = 1'b1;
      sw_num_next  = sw_trap_num_i;
    end
    req_next = (req_reg & ~node_clr) | src_req;             // RULE9
    if (node_reset) begin
      req_next[cur_node_reg] = 1'b1;                        // RULE6
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg     <= ST_IDLE;
      lat_reg       <= '0;
      cur_node_reg  <= '0;
      cur_chan_reg  <= '0;
      cur_sw_reg    <= 1'b0;
      sw_pend_reg   <= 1'b0;
      sw_num_reg    <= '0;
      req_reg       <= '0;
      int_vec_reg   <= '0;
      int_lvl_reg   <= '0;
      int_req_reg   <= 1'b0;
      pec_steal_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      lat_reg       <= lat_next;
      cur_node_reg  <= cur_node_next;
      cur_chan_reg  <= cur_chan_next;
      cur_sw_reg    <= cur_sw_next;
      sw_pend_reg   <= sw_pend_next;
      sw_num_reg    <= sw_num_next;
      req_reg       <= req_next;
      int_vec_reg   <= int_vec_next;
      int_lvl_reg   <= int_lvl_next;
      int_req_reg   <= (state_next == ST_INT);
      pec_steal_reg <= (state_next == ST_PEC);              // RULE3
    end
  end

  // ---------------------------------------------------------------------
  // Transfer engine channels
  // ---------------------------------------------------------------------
  logic [ADDR_W-1:0]   src_reg  [NUM_PEC];
  logic [ADDR_W-1:0]   dst_reg  [NUM_PEC];
  logic [ADDR_W-1:0]   src_next [NUM_PEC];
  logic [ADDR_W-1:0]   dst_next [NUM_PEC];
  logic [CNT_W-1:0]    cnt_next [NUM_PEC];
  logic [ADDR_W-1:0]   step;
  logic [ADDR_W-1:0]   xfer_src_reg, xfer_dst_reg;
  logic [PEC_CH_W-1:0] xfer_chan_reg;
  logic                xfer_word_reg;

  // Pointer and counter update; a software load wins
  always_comb begin
    step = PTR_STEP_BYTE;
    for (int c = 0; c < NUM_PEC; c++) begin                 // RULE7
      src_next[c] = src_reg[c];
      dst_next[c] = dst_reg[c];
      cnt_next[c] = cnt_reg[c];
      if (state_reg == ST_PEC && cur_chan_reg == PEC_CH_W'(c)) begin
        step = pec_word_i[c] ? PTR_STEP_WORD : PTR_STEP_BYTE; // RULE4
        if (pec_inc_src_i[c]) begin
          src_next[c] = src_reg[c] + step;                  // RULE4
        end
        if (pec_inc_dst_i[c]) begin
          dst_next[c] = dst_reg[c] + step;                  // RULE4
        end
        if (!pec_cont_i[c] && cnt_reg[c] != '0) begin
          cnt_next[c] = cnt_reg[c] - 1'b1;                  // RULE5
        end
      end
      if (pec_load_i && pec_load_chan_i == PEC_CH_W'(c)) begin
        src_next[c] = pec_load_src_i;
        dst_next[c] = pec_load_dst_i;
        cnt_next[c] = pec_load_cnt_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_PEC; c++) begin
        src_reg[c] <= ADDR_RST;
        dst_reg[c] <= ADDR_RST;
        cnt_reg[c] <= PEC_CNT_RST;
      end
      xfer_src_reg  <= ADDR_RST;
      xfer_dst_reg  <= ADDR_RST;
      xfer_chan_reg <= '0;
      xfer_word_reg <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_PEC; c++) begin
        src_reg[c] <= src_next[c];
        dst_reg[c] <= dst_next[c];
        cnt_reg[c] <= cnt_next[c];
      end
      // Transfer addresses stand with the stolen cycle
      if (state_next == ST_PEC) begin
        xfer_src_reg  <= src_reg[win_chan];
        xfer_dst_reg  <= dst_reg[win_chan];
        xfer_chan_reg <= win_chan;
        xfer_word_reg <= pec_word_i[win_chan];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Hardware and system-request traps
  // ---------------------------------------------------------------------
  logic [NUM_TRAPS-1:0] tfr_reg, tfr_next, taken_reg, taken_next;
  logic [NUM_TRAPS-1:0] trap_set;
  logic [TRAP_W-1:0]    pick, cur_trap_reg, cur_trap_next;
  logic                 pick_valid, trap_busy_next;
  logic                 trap_req_reg, trap_req_next;
  logic [VEC_W-1:0]     trap_vec_reg, trap_vec_next;
  logic [NUM_ESR-1:0]   esr_rise;

  // Capture flags, issue lowest index unless outranked
  always_comb begin
    esr_rise = pin_rise[NUM_PINS-1:ERU_CH] & esr_en_i;
    trap_set = '0;
    trap_set[NUM_TRAPS-3:0]  = hw_trap_i;
    trap_set[TRAP_SR0_BIT]   = esr_rise[0];                 // RULE17
    trap_set[TRAP_SR1_BIT]   = |esr_rise[NUM_ESR-1:1];      // RULE17
    tfr_next   = (tfr_reg & ~trap_flag_clr_i) | trap_set;   // RULE14
    taken_next = taken_reg & tfr_next;
    pick       = '0;
    pick_valid = 1'b0;
    for (int t = NUM_TRAPS - 1; t >= 0; t--) begin
      if (tfr_reg[t] && !taken_reg[t]) begin
        pick       = TRAP_W'(t);
        pick_valid = 1'b1;
      end
    end
    trap_busy_next = trap_busy_reg;
    cur_trap_next  = cur_trap_reg;
    trap_req_next  = 1'b0;
    trap_vec_next  = trap_vec_reg;
    if (pick_valid && (!trap_busy_reg || pick < cur_trap_reg)) begin // RULE15
      taken_next[pick] = 1'b1;
      trap_busy_next   = 1'b1;                              // RULE16
      cur_trap_next    = pick;
      trap_req_next    = 1'b1;
      trap_vec_next    = TRAP_VEC_BASE + {{(VEC_W-TRAP_W){1'b0}}, pick}; // RULE14
    end else if (trap_done_i) begin
      trap_busy_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tfr_reg       <= '0;
      taken_reg     <= '0;
      trap_busy_reg <= 1'b0;
      cur_trap_reg  <= '0;
      trap_req_reg  <= 1'b0;
      trap_vec_reg  <= '0;
    end else begin
      tfr_reg       <= tfr_next;
      taken_reg     <= taken_next;
      trap_busy_reg <= trap_busy_next;
      cur_trap_reg  <= cur_trap_next;
      trap_req_reg  <= trap_req_next;
      trap_vec_reg  <= trap_vec_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all straight from registers
  // ---------------------------------------------------------------------
  assign int_req_o       = int_req_reg;
  assign int_vec_o       = int_vec_reg;
  assign int_level_o     = int_lvl_reg;
  assign node_pend_o     = req_reg;
  assign pec_steal_o     = pec_steal_reg;
  assign pec_chan_o      = xfer_chan_reg;
  assign pec_src_addr_o  = xfer_src_reg;
  assign pec_dst_addr_o  = xfer_dst_reg;
  assign pec_word_o      = xfer_word_reg;
  assign eru_out_o       = eru_out_reg;
  assign trap_req_o      = trap_req_reg;
  assign trap_vec_o      = trap_vec_reg;
  assign trap_flag_reg_o = tfr_reg;
  assign trap_busy_o     = trap_busy_reg;

endmodule : iets_top
`default_nettype wire

// ===== tb/iets_cpu_model.sv
// Purpose: CPU model that takes interrupts and ends traps
// Assumes: slow_i adds four wait cycles
// Notes:   Acknowledge and done are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module iets_cpu_model (
  // Clock, reset and pace
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  // Requests from the block
  input  wire logic int_req_i,
  input  wire logic trap_busy_i,
  // Answers
  output logic      int_ack_o,
  output logic      trap_done_o
);
  logic [2:0] wait_reg;
  // Count the pause, then answer once per request
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_reg    <= 3'h0;
      int_ack_o   <= 1'b0;
      trap_done_o <= 1'b0;
    end else begin
      wait_reg    <= (int_req_i | trap_busy_i) ? wait_reg + 3'h1 : 3'h0;
      int_ack_o   <= int_req_i & ~int_ack_o & (wait_reg >= {slow_i, 2'h0});
      trap_done_o <= trap_busy_i & ~trap_done_o & (wait_reg >= {slow_i, 2'h0});
    end
  end
endmodule : iets_cpu_model
`default_nettype wire

// ===== tb/iets_monitor.sv
// Purpose: Port checker for the interrupt and trap block
// Assumes: cpu_level_i steady during service
// Notes:   Bound to iets_top after the module
`timescale 1ns/1ps
`default_nettype none
module iets_monitor
  import iets_pkg::*;
(
  // Clock, reset and inputs
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic                 int_ack_i,
  input wire logic [PRIO_W-1:0]    cpu_level_i,
  input wire logic [NUM_TRAPS-3:0] hw_trap_i,
  // Watched outputs
  input wire logic                 int_req_o,
  input wire logic [VEC_W-1:0]     int_vec_o,
  input wire logic [PRIO_W-1:0]    int_level_o,
  input wire logic                 pec_steal_o,
  input wire logic [ADDR_W-1:0]    pec_src_addr_o,
  input wire logic                 trap_req_o,
  input wire logic [VEC_W-1:0]     trap_vec_o,
  input wire logic [NUM_TRAPS-1:0] trap_flag_reg_o,
  input wire logic                 trap_busy_o
);
  // One clock for all checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_steal_one_cycle: assert property (
    pec_steal_o |=> !pec_steal_o) else $error("steal too long");
  a_addr_hold: assert property (
    $changed(pec_src_addr_o) |-> pec_steal_o) else $error("addr moved");
  a_int_hold: assert property (
    int_req_o && !int_ack_i |=> int_req_o && $stable(int_vec_o))
    else $error("int dropped");
  a_int_drop: assert property (
    int_req_o && int_ack_i |=> !int_req_o) else $error("request kept");
  a_trap_flag_vec: assert property (
    trap_req_o |-> trap_flag_reg_o[trap_vec_o[TRAP_W-1:0]] ##1 !trap_req_o)
    else $error("trap issue wrong");
  a_trap_flag_set: assert property (
    |hw_trap_i |=> (trap_flag_reg_o[5:0] & $past(hw_trap_i)) ==
    $past(hw_trap_i)) else $error("flag not set");
  a_trap_blocks_int: assert property (
    $rose(int_req_o) |-> !$past(trap_busy_o)) else $error("trap preempted");
  a_level_above_cpu: assert property (
    $rose(int_req_o) |-> int_level_o > cpu_level_i) else $error("low level");
endmodule : iets_monitor
bind iets_top iets_monitor u_mon (.*);
`default_nettype wire

// ===== tb/iets_top_tb.sv
// Purpose: Self-checking bench for iets_top
// Assumes: Latency 7 or 11 clocks
// Notes:   Expected results queued per request
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t %h %h", $time, a, b); end end
module iets_top_tb;
  import iets_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0, jump_cache_i = 1'b1;
  logic request_set_bit_i = 1'b0, sw_trap_i = 1'b0, pec_load_i = 1'b0;
  logic int_ack_i, trap_done_i, int_req_o, pec_steal_o, trap_req_o;
  logic trap_busy_o, int_prev = 1'b0;
  logic [SHARED_BASE-1:0] hw_req_i = '0;
  logic [VEC_W-1:0] request_set_node_i = '0, sw_trap_num_i = '0;
  logic [VEC_W-1:0] int_vec_o, trap_vec_o;
  logic [NUM_TRAPS-1:0] trap_flag_clr_i = '0, trap_flag_reg_o;
  logic [NUM_TRAPS-3:0] hw_trap_i = '0;
  logic [ADDR_W-1:0] pec_load_src_i = '0, pec_load_dst_i = '0;
  logic [ADDR_W-1:0] src, pec_src_addr_o;
  logic [94:0] nz = '0;
  logic [17:0] exp_q[$], act, want;
  logic [3:0] cpu_level_i = 4'h1;
  logic [7:0] pec_word_i = 8'h04, pec_inc_src_i = 8'h04, pec_inc_dst_i = '0;
  logic [7:0] pec_cont_i = '0, pec_load_cnt_i = 8'h02;
  logic [2:0] pec_load_chan_i = 3'h2, esr_en_i = '0;
  int seed = 32'hccbd, miscompares = 0, n_compared = 0;
  iets_top dut (.*, .shared_a_i(nz[7:0]), .shared_b_i(nz[15:8]),
    .source_select_regs_i(nz[23:16]), .node_en_i({16'h0, {80{1'b1}}}),
    .node_prio_i({96{4'h5}}), .pec_route_i(96'h80), .node_chan_i({96{3'h2}}),
    .eru_pin_i(nz[27:24]), .eru_edge_cfg_i(nz[35:28]),
    .eru_route_i(nz[51:36]), .eru_pat_mask_i(nz[67:52]),
    .eru_pat_val_i(nz[83:68]), .eru_gate_i(nz[91:84]),
    .external_service_pin_i(nz[94:92]), .int_level_o(),
    .node_pend_o(), .pec_chan_o(), .pec_dst_addr_o(), .pec_word_o(),
    .eru_out_o());
  iets_cpu_model u_cpu (.sys_clk_i, .rst_i, .slow_i(slow),
    .int_req_i(int_req_o), .trap_busy_i(trap_busy_o),
    .int_ack_o(int_ack_i), .trap_done_o(trap_done_i));
  // Clock and random pin traffic
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) nz <= 95'({$random(seed), $random(seed),
    $random(seed)});
  // Watcher pops one note per result
  always @(negedge sys_clk_i) begin
    if ((int_req_o && !int_prev) || pec_steal_o || trap_req_o) begin
      act = pec_steal_o ? {2'h1, pec_src_addr_o} : trap_req_o ?
        {2'h2, 9'h0, trap_vec_o} : {2'h0, 9'h0, int_vec_o};
      want = exp_q.size() > 0 ? exp_q.pop_front() : 18'h3FFFF;
      `CHK(act, want)
    end
    int_prev = int_req_o;
  end
  // Pulse a source, time the response
  task automatic go(input int what, input int n, input logic jc,
                    input int lat);
    int k, hit;
    k = 0;
    hit = 0;
    @(posedge sys_clk_i);
    jump_cache_i <= jc;
    case (what)
      0: hw_req_i[n] <= 1'b1;
      1: begin request_set_bit_i <= 1'b1; request_set_node_i <= n[6:0]; end
      2: begin sw_trap_i <= 1'b1; sw_trap_num_i <= n[6:0]; end
      default: hw_trap_i[n] <= 1'b1;
    endcase
    do begin
      @(posedge sys_clk_i);
      {hw_req_i, request_set_bit_i, sw_trap_i, hw_trap_i, pec_load_i} <= '0;
      k++;
      #1;
      if (int_req_o && hit == 0) hit = k;
    end while ((k < 40 || int_req_o || trap_busy_o) && k < 99);
    if (k >= 99) begin miscompares++; end_of_test(); end
    if (lat != 0) `CHK(hit, lat)
  endtask : go
  task automatic end_of_test();
    $display("compared %0d miscompared %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    exp_q.push_back(18'h00013);
    go(0, 3, 1'b1, 8);
    exp_q.push_back(18'h00013);
    go(0, 3, 1'b0, 12);
    src = 16'($random(seed));
    pec_load_i <= 1'b1;
    pec_load_src_i <= src;
    pec_load_dst_i <= 16'($random(seed));
    exp_q.push_back({2'h1, src});
    go(0, 7, 1'b1, 0);
    exp_q.push_back({2'h1, src + PTR_STEP_WORD});
    exp_q.push_back(18'h00017);
    go(0, 7, 1'b1, 10);
    exp_q.push_back(18'h20002);
    slow <= 1'b1;
    go(3, 2, 1'b1, 0);
    `CHK(trap_flag_reg_o, 8'h04)
    trap_flag_clr_i <= 8'hFF;
    exp_q.push_back(18'h00025);
    go(2, 37, 1'b1, 8);
    exp_q.push_back(18'h00019);
    go(1, 9, 1'b1, 8);
    end_of_test();
  end
endmodule : iets_top_tb
`default_nettype wire
